//--- design/sipol_latch.sv
`timescale 1ns/1ps
module sipol_latch
    import sipol_pkg::*;
#(
    parameter int unsigned WIDTH = STAGE_COUNT
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_clk_en,
    input  wire logic             i_data_in_bit,
    input  wire logic             i_shift_clk,
    input  wire logic             i_latch_clk,
    input  wire logic             i_shift_clear_n,
    input  wire logic             i_output_drive_enable_n,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_parallel_out,
    output logic      [WIDTH-1:0] o_parallel_out_oe,
    output logic                  o_cascade_out,
    output logic      [WIDTH-1:0] o_word_data,
    output logic                  o_word_valid
);
    import sipol_pkg::*;

    // pins are asynchronous; all pins pass two flops before any logic
    sipol_pins_type sync1_reg, sync1_next;
    sipol_pins_type sync2_reg, sync2_next;
    sipol_pins_type prev_reg,  prev_next;
    logic           clr_n1_reg, clr_n2_reg;
    logic           oe_n1_reg,  oe_n2_reg;
    logic [WIDTH-1:0] shift_reg, shift_next;
    logic [WIDTH-1:0] store_reg, store_next;
    logic [WIDTH-1:0] buf_mem [BUF_DEPTH];
    logic [WIDTH-1:0] buf0_next, buf1_next;
    logic [1:0]       cnt_reg, cnt_next;
    logic             shift_rise, latch_rise;

    // one-cycle strobe when a synchronised pin goes from low to high
    function automatic logic rise_of(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    always_comb begin
        sync1_next = '{i_data_in_bit, i_shift_clk, i_latch_clk};
        sync2_next = sync1_reg;
        prev_next  = sync2_reg;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_reg  <= SYNC_RST_VAL;
            sync2_reg  <= SYNC_RST_VAL;
            prev_reg   <= SYNC_RST_VAL;
            clr_n1_reg <= 1'b0;
            clr_n2_reg <= 1'b0;
            oe_n1_reg  <= 1'b1;
            oe_n2_reg  <= 1'b1;
        end else if (i_clk_en) begin
            sync1_reg  <= sync1_next;
            sync2_reg  <= sync2_next;
            prev_reg   <= prev_next;
            clr_n1_reg <= i_shift_clear_n;
            clr_n2_reg <= clr_n1_reg;
            oe_n1_reg  <= i_output_drive_enable_n;
            oe_n2_reg  <= oe_n1_reg;
        end
    end

    // rising edges of the synchronised clock pins
    // prev_reg is reset low like the pins' idle level, so no false edge
    assign shift_rise = rise_of(sync2_reg.shift_clk,
                                prev_reg.shift_clk);
    assign latch_rise = rise_of(sync2_reg.latch_clk,
                                prev_reg.latch_clk);

    always_comb begin
        shift_next = shift_reg;
        store_next = store_reg;
        if (latch_rise) begin
            // reads the old shift value, so a tied clock trails by one
            store_next = shift_reg;
        end
        if (!clr_n2_reg) begin
            shift_next = SHIFT_RST_VAL;
        end else if (shift_rise) begin
            shift_next = {shift_reg[WIDTH-2:0],
                          sync2_reg.data_in_bit};
        end
    end

    // clear needs no shift edge; being synchronised it acts two to three
    // cycles after the pin, which keeps the stages glitch free
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_reg <= SHIFT_RST_VAL;
            store_reg <= STORE_RST_VAL;
        end else if (i_clk_en) begin
            shift_reg <= shift_next;
            store_reg <= store_next;
        end
    end

    assign o_parallel_out    = store_reg;
    assign o_parallel_out_oe = {WIDTH{~oe_n2_reg}};
    assign o_cascade_out     = shift_reg[WIDTH-1];

    // two-entry buffer of latched words; a stalled sink keeps what is
    // queued, but a latch edge that finds both entries full with no word leaving is not queued
    always_comb begin
        buf0_next = buf_mem[0];
        buf1_next = buf_mem[1];
        cnt_next  = cnt_reg;
        if (o_word_valid && i_out_ready) begin
            buf0_next = buf_mem[1];
            cnt_next  = cnt_reg - 2'h1;
        end
        if (latch_rise && (cnt_next != 2'h2)) begin
            if (cnt_next == 2'h0) begin
                buf0_next = shift_reg;
            end else begin
                buf1_next = shift_reg;
            end
            cnt_next = cnt_next + 2'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            buf_mem[0] <= STORE_RST_VAL;
            buf_mem[1] <= STORE_RST_VAL;
            cnt_reg    <= 2'h0;
        end else if (i_clk_en) begin
            buf_mem[0] <= buf0_next;
            buf_mem[1] <= buf1_next;
            cnt_reg    <= cnt_next;
        end
    end

    assign o_word_data  = buf_mem[0];
    assign o_word_valid = (cnt_reg != 2'h0);

    chk_clear_zeroes: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && !clr_n2_reg |=> shift_reg == '0)
        else $error("shift stages not zero after clear");

    chk_shift_moves: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && clr_n2_reg && shift_rise |=>
        shift_reg == {$past(shift_reg[WIDTH-2:0]),
                      $past(sync2_reg.data_in_bit)})
        else $error("shift stage did not advance");

    chk_latch_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && latch_rise |=> store_reg == $past(shift_reg))
        else $error("storage did not capture shift stages");

    chk_store_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !latch_rise |=> $stable(store_reg))
        else $error("storage changed without latch edge");

    chk_oe_follows: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_parallel_out_oe == {WIDTH{~oe_n2_reg}})
        else $error("output enable mismatch");

    chk_cascade_tail: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_cascade_out == shift_reg[WIDTH-1])
        else $error("cascade not last stage");

    chk_tied_trail: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && clr_n2_reg && shift_rise && latch_rise |=>
        store_reg == $past(shift_reg) && store_reg != shift_reg
        || $past(shift_reg) == shift_reg)
        else $error("tied clocks storage not trailing");

    chk_edge_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && shift_rise |=> !shift_rise)
        else $error("shift edge lasted two cycles");

    chk_latch_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && latch_rise |=> !latch_rise)
        else $error("latch edge lasted two cycles");

    chk_freeze_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_clk_en |=> $stable(shift_reg) && $stable(store_reg)
        && $stable(cnt_reg))
        else $error("state moved while clock enable low");

    chk_clear_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !clr_n2_reg && !latch_rise |=> $stable(store_reg))
        else $error("clear disturbed storage register");

    chk_store_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_parallel_out == store_reg)
        else $error("parallel outputs not storage value");

    chk_cascade_step: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && clr_n2_reg && shift_rise |=>
        o_cascade_out == $past(shift_reg[WIDTH-2]))
        else $error("cascade did not take next to last stage");

    chk_buf_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        cnt_reg <= 2'h2)
        else $error("buffer count beyond two entries");

    chk_buf_push: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && latch_rise && cnt_reg == 2'h0 |=>
        o_word_valid && o_word_data == $past(shift_reg))
        else $error("latched word not queued in empty buffer");

    chk_buf_stall: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_clk_en && cnt_reg == 2'h2 && !i_out_ready |=>
        cnt_reg == 2'h2 && $stable(o_word_data))
        else $error("stalled full buffer lost its head word");
endmodule

//--- design/sipol_pkg.sv
package sipol_pkg;
    localparam int unsigned STAGE_COUNT   = 8;
    localparam logic [7:0]  SHIFT_RST_VAL = 8'h00;
    localparam logic [7:0]  STORE_RST_VAL = 8'h00;
    localparam logic [2:0]  SYNC_RST_VAL  = 3'h0;
    localparam int unsigned BUF_DEPTH     = 2;

    // pin-side inputs after synchronisation
    typedef struct packed {
        logic data_in_bit;
        logic shift_clk;
        logic latch_clk;
    } sipol_pins_type;
endpackage

//--- sim/sipol_host.sv
`timescale 1ns/1ps
module sipol_host (
    input  wire logic i_clk,
    output logic      o_data_in_bit,
    output logic      o_shift_clk,
    output logic      o_latch_clk
);
    initial begin
        o_data_in_bit = 1'b0;
        o_shift_clk   = 1'b0;
        o_latch_clk   = 1'b0;
    end
    // levels held 4 cycles so the pin synchroniser cannot miss a pulse
    task automatic pulse(input logic s, input logic l, input logic d);
        @(negedge i_clk);
        o_data_in_bit <= d;
        repeat (4) @(negedge i_clk);
        o_shift_clk <= s;
        o_latch_clk <= l;
        repeat (4) @(negedge i_clk);
        o_shift_clk   <= 1'b0;
        o_latch_clk   <= 1'b0;
        o_data_in_bit <= ~d;
    endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
    import sipol_pkg::*;
    logic       clk, rst, clr_n, oe_n, rdy, din, sck, lck, casc, vld, en;
    logic [7:0] po, poe, wd, sr, st, lf;
    logic [7:0] q[$];
    int         num_errors, samples_checked;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    sipol_host host (.i_clk(clk), .o_data_in_bit(din), .o_shift_clk(sck),
        .o_latch_clk(lck));
    sipol_latch uut (.i_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
        .i_data_in_bit(din), .i_shift_clk(sck), .i_latch_clk(lck),
        .i_shift_clear_n(clr_n), .i_output_drive_enable_n(oe_n),
        .i_out_ready(rdy), .o_parallel_out(po), .o_parallel_out_oe(poe),
        .o_cascade_out(casc), .o_word_data(wd), .o_word_valid(vld));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the model updates before the pins move, pre-shift value for a latch
    task automatic op(input logic s, input logic l, input logic d);
        if (l) begin
            st = sr;
            if (q.size() < BUF_DEPTH)
                q.push_back(sr);
        end
        if (s && clr_n)
            sr = {sr[6:0], d};
        host.pulse(s, l, d);
        repeat (4) @(negedge clk);
        chk(po, st);
        chk({7'h0, casc}, {7'h0, sr[7]});
    endtask
    // looked at mid-cycle, once the word has settled; it leaves at the
    // next rising edge because ready is high
    always @(negedge clk) begin
        if (!rst && vld === 1'b1 && rdy === 1'b1)
            chk(wd, (q.size() > 0) ? q.pop_front() : ~wd);
    end
    initial begin
        #(2000 * 25);
        num_errors++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        clr_n = 1'b1;
        oe_n = 1'b0;
        rdy = 1'b1;
        en = 1'b1;
        sr = SHIFT_RST_VAL;
        st = STORE_RST_VAL;
        lf = 8'h49;
        num_errors = 0;
        samples_checked = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk(poe, 8'hFF);
        for (int i = 0; i < 16; i++) begin
            lf = lfsr(lf);
            op(1'b1, i[2:0] == 3'h7, lf[0]);
        end
        op(1'b0, 1'b1, 1'b1);
        oe_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(poe, 8'h00);
        op(1'b1, 1'b0, 1'b1);
        clr_n = 1'b0;
        sr = 8'h00;
        repeat (6) @(negedge clk);
        op(1'b1, 1'b0, 1'b1);
        clr_n = 1'b1;
        oe_n = 1'b0;
        repeat (4) @(negedge clk);
        op(1'b0, 1'b1, 1'b0);
        en = 1'b0;
        repeat (5) @(negedge clk);
        en = 1'b1;
        repeat (2) @(negedge clk);
        chk(po, st);
        rdy = 1'b0;
        for (int i = 0; i < 3; i++) begin
            lf = lfsr(lf);
            op(1'b1, 1'b0, lf[0]);
            op(1'b0, 1'b1, 1'b0);
        end
        rdy = 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h0, q.size() == 0}, 8'h01);
        final_report();
    end
endmodule
